// [sleep_mode_controller_tb_top.sv]
// Purpose: self-checking bench joining both ends of the controller
// Assumes: 100 MHz clock, synchronous active-high reset
// Notes:   wake timing is checked to the exact cycle count
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_controller_tb_top;
  import smc_pkg::*;
  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] cfg;
    logic [3:0] ck;
    logic [7:0] wake;
    logic [4:0] clks;
    logic [5:0] lo;
  } smc_row_t;
  logic clk_sys_i, sys_rst_i, wr_i, rd_i, sleep_cmd_i, rst_req_i, adc_enabled_i;
  logic halted_o, run_isr_o, jump_reset_o;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, wake_src_i;
  int n_errors, cmp_count, cyc;
  smc_row_t r;
  // mode, cfg, clock select, wake source, clocks {cpu,flash,io,adc,asy}, start-up plus halt cycles
  smc_row_t rows [7] = '{'{3'h0, 8'h00, 4'h1, 8'h80, 5'h07, 6'h05}, '{3'h1, 8'h00, 4'h1, 8'h01, 5'h03, 6'h05},
    '{3'h2, 8'h00, 4'h1, 8'h10, 5'h00, 6'h0a}, '{3'h2, 8'h00, 4'h5, 8'h02, 5'h00, 6'h16},
    '{3'h2, 8'h30, 4'h8, 8'h02, 5'h00, 6'h0a}, '{3'h3, 8'h01, 4'h1, 8'h04, 5'h01, 6'h0a},
    '{3'h6, 8'h04, 4'h1, 8'h02, 5'h00, 6'h0a}};
  smc_if smc_if_inst ();
  smc_device smc_device_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .lnk(smc_if_inst));
  smc_host smc_host_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_cmd_i(sleep_cmd_i), .wake_src_i(wake_src_i),
    .rst_req_i(rst_req_i), .adc_enabled_i(adc_enabled_i), .halted_o(halted_o), .run_isr_o(run_isr_o),
    .jump_reset_o(jump_reset_o), .lnk(smc_if_inst));
  smc_asserts smc_asserts_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ctrl_rdata(smc_if_inst.ctrl_rdata),
    .sleep_instr(smc_if_inst.sleep_instr), .wake_src(smc_if_inst.wake_src), .rst_req(smc_if_inst.rst_req),
    .async_t2(smc_if_inst.async_t2), .xtal_sel(smc_if_inst.xtal_sel), .adc_enabled(smc_if_inst.adc_enabled),
    .clk_en(smc_if_inst.clk_en), .main_osc_en(smc_if_inst.main_osc_en), .timer_osc_en(smc_if_inst.timer_osc_en),
    .adc_start(smc_if_inst.adc_start), .core_halt(smc_if_inst.core_halt), .jump_reset(smc_if_inst.jump_reset),
    .asleep(smc_if_inst.asleep));
  // ****************************************************************
  // clock, timeout and reporting
  // ****************************************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // whole run is a few hundred cycles, so a hang shows well before this
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // ****************************************************************
  // bus and core actions
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_sys_i) wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys_i) {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_sys_i) rd_i <= 1'b0;
    #1 chk(what, exp, rdata_o);
  endtask
  // one sleep instruction, then the halt flag is compared once it settles
  task automatic go(input logic exp);
    @(posedge clk_sys_i) sleep_cmd_i <= 1'b1;
    @(posedge clk_sys_i) sleep_cmd_i <= 1'b0;
    #1 chk("halted", 8'(exp), 8'(halted_o));
  endtask
  // level source is held until the core runs again, as the far side must
  task automatic wake(input logic [7:0] src, input logic [5:0] lo);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(posedge clk_sys_i) wake_src_i <= src;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
      seen |= run_isr_o;
    end while (halted_o && n < 60);
    @(posedge clk_sys_i) wake_src_i <= 8'h00;
    #1 seen |= run_isr_o;
    chk("wake cycles", 8'(lo) + 8'h01, 8'(n));
    chk("isr pulse", 8'h01, 8'(seen));
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {sys_rst_i, adc_enabled_i} = 2'b11;
    {wr_i, rd_i, sleep_cmd_i, rst_req_i, addr_i, wdata_i, wake_src_i} = '0;
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      wr(SMC_ADDR_CFG, r.cfg);
      wr(SMC_ADDR_STATUS, {4'h0, r.ck});
      wr(SMC_ADDR_CTRL, {1'b1, r.mode, 4'h5});
      go(1'b1);
      chk("clocks", 8'(r.clks), 8'(smc_if_inst.clk_en));
      wake(r.wake, r.lo);
      rd(SMC_ADDR_CTRL, {1'b1, r.mode, 4'h5}, "ctrl kept");
      $display("row %0d done", i);
    end
    // a second reset in mid-run brings every register back
    @(posedge clk_sys_i) sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(SMC_ADDR_CTRL, 8'h00, "ctrl reset");
    rd(SMC_ADDR_STATUS, 8'h01, "status reset");
    wr(SMC_ADDR_CTRL, 8'h5a);
    rd(SMC_ADDR_CTRL, 8'h5a, "ctrl rw");
    rd(4'hf, 8'h00, "unmapped");
    $display("register test done");
    wr(SMC_ADDR_CTRL, 8'h20);
    go(1'b0);
    for (int m = 4; m < 7; m++) begin
      wr(SMC_ADDR_CTRL, {1'b1, 3'(m), 4'h0});
      go(1'b0);
    end
    $display("refusal test done");
    // sources outside the mode's list, or a powered-down comparator, must not end sleep
    for (int k = 0; k < 2; k++) begin
      wr(SMC_ADDR_CFG, k ? 8'h02 : 8'h00);
      wr(SMC_ADDR_CTRL, k ? 8'h80 : 8'h90);
      go(1'b1);
      @(posedge clk_sys_i) wake_src_i <= k ? 8'h40 : 8'he0;
      repeat (10) @(posedge clk_sys_i);
      #1 chk("masked halted", 8'h01, 8'(halted_o));
      wake(k ? 8'h80 : 8'h08, 6'h05);
    end
    $display("masking test done");
    wr(SMC_ADDR_CTRL, 8'ha0);
    go(1'b1);
    @(posedge clk_sys_i) wake_src_i <= 8'h41;
    repeat (10) @(posedge clk_sys_i);
    #1 chk("deaf halted", 8'h01, 8'(halted_o));
    @(posedge clk_sys_i) rst_req_i <= 1'b1;
    #1 chk("jump reset", 8'h01, 8'(jump_reset_o));
    @(posedge clk_sys_i) {rst_req_i, wake_src_i} <= 9'h000;
    #1 chk("reset woke", 8'h00, 8'(halted_o));
    $display("reset wake test done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// [smc_asserts.sv]
// Purpose: interface checks for the sleep mode controller
// Assumes: one clock, synchronous active-high reset
// Notes:   the sleep mode is read from the control register copy
`timescale 1ns/1ps
`default_nettype none
module smc_asserts
  import smc_pkg::*;
(
  input wire logic               clk_sys_i,
  input wire logic               sys_rst_i,
  input wire logic [7:0]         ctrl_rdata,
  input wire logic               sleep_instr,
  input wire logic [SMC_W_N-1:0] wake_src,
  input wire logic               rst_req,
  input wire logic               async_t2,
  input wire logic               xtal_sel,
  input wire logic               adc_enabled,
  input wire smc_clk_t           clk_en,
  input wire logic               main_osc_en,
  input wire logic               timer_osc_en,
  input wire logic               adc_start,
  input wire logic               core_halt,
  input wire logic               jump_reset,
  input wire logic               asleep
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic [2:0] mode;
  // mode field is only meaningful while the core sleeps or issues sleep
  assign mode = ctrl_rdata[6:4];
  // ****************************************************************
  // entry into sleep
  // ****************************************************************
  sequence go_s;
    sleep_instr && !core_halt;
  endsequence
  sequence take_s;
    go_s ##0 ctrl_rdata[7] && (mode <= 3'h3 || (mode == SMC_M_STBY && xtal_sel));
  endsequence
  no_enable_a: assert property (go_s ##0 !ctrl_rdata[7] |=> !asleep)
    else $error("sleep taken with enable clear");
  bad_mode_a: assert property (go_s ##0 (mode[2:1] == 2'h2 || (mode == SMC_M_STBY && !xtal_sel))
    |=> !asleep && !core_halt) else $error("reserved mode not ignored");
  enter_halt_a: assert property (take_s |=> core_halt && asleep)
    else $error("valid sleep not entered");
  adc_kick_a: assert property (take_s ##0 mode <= 3'h1 && adc_enabled |=> adc_start)
    else $error("no conversion start on entry");
  // ****************************************************************
  // clock domains per mode
  // ****************************************************************
  idle_clocks_a: assert property (asleep && mode == SMC_M_IDLE |-> clk_en == 5'h07 && main_osc_en)
    else $error("idle clock gating wrong");
  adc_clocks_a: assert property (asleep && mode == SMC_M_ADCNR |-> clk_en == 5'h03 && main_osc_en)
    else $error("adc mode clock gating wrong");
  pdown_clocks_a: assert property (asleep && mode == SMC_M_PDOWN |-> clk_en == 5'h00 && !main_osc_en)
    else $error("power-down clock gating wrong");
  psave_clocks_a: assert property (asleep && mode == SMC_M_PSAVE
    |-> clk_en == {4'h0, async_t2} && timer_osc_en == async_t2 && !main_osc_en)
    else $error("power-save clock gating wrong");
  stby_clocks_a: assert property (asleep && mode == SMC_M_STBY |-> clk_en == 5'h00 && main_osc_en)
    else $error("standby clock gating wrong");
  // ****************************************************************
  // wake-up
  // ****************************************************************
  pdown_deaf_a: assert property (asleep && mode == SMC_M_PDOWN && wake_src == 8'h41 && !rst_req
    |=> asleep) else $error("power-down woke on a masked source");
  adc_deaf_a: assert property (asleep && mode == SMC_M_ADCNR && wake_src[4:0] == 5'h00 && !rst_req
    |=> asleep) else $error("adc mode woke on a masked source");
  stby_wake_a: assert property (asleep && mode == SMC_M_STBY && wake_src[SMC_W_TWI]
    |-> core_halt [*8] ##1 core_halt [*3] ##1 !core_halt) else $error("standby wake time wrong");
  reset_wake_a: assert property (asleep && rst_req |-> jump_reset ##1 !core_halt)
    else $error("reset during sleep not taken");
  keep_enable_a: assert property ($fell(core_halt) && !$past(jump_reset) |-> ctrl_rdata[7])
    else $error("enable bit cleared on wake");
endmodule
`default_nettype wire

// [smc_device.sv]
// Purpose: sleep mode controller, device end
// Assumes: wake sources already qualified by their own enables
// Notes:   register file and sram clocks only gated, never reset
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module smc_device
  import smc_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  smc_if.dev        lnk
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // start-up delay from fuse settings
  function automatic logic [4:0] smc_startup(input logic [3:0] ck, input logic [1:0] su);
    if (ck >= SMC_CK_ERC_LO && ck <= SMC_CK_ERC_HI && su != 2'h3) begin
      smc_startup = SMC_SU_LONG;
    end else begin
      smc_startup = SMC_SU_SHORT;
    end
  endfunction

  // mode is legal to enter
  function automatic logic smc_valid(input logic [2:0] m, input logic xtal);
    case (m)
      SMC_M_IDLE, SMC_M_ADCNR, SMC_M_PDOWN, SMC_M_PSAVE: smc_valid = 1'b1;
      SMC_M_STBY: smc_valid = xtal;
      default:    smc_valid = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]  ctrl_reg;
  smc_state_t  state_reg;
  logic [2:0]  mode_reg;
  logic [4:0]  cnt_reg;
  logic        isr_reg;
  logic        adc_start_reg;
  logic        wake;
  logic        enter;
  logic [SMC_W_N-1:0] allow;

  // ****************************************************************
  // control register
  // ****************************************************************
  // all bits plain read/write; hardware never touches the enable bit
  // a write and a sleep in one cycle: the sleep still sees the old value
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= SMC_CTRL_RESET;
    end else if (lnk.ctrl_we) begin
      ctrl_reg <= lnk.ctrl_wdata;
    end
  end
  assign lnk.ctrl_rdata = ctrl_reg;

  assign enter = lnk.sleep_instr && ctrl_reg[SMC_SE_POS]
              && smc_valid(ctrl_reg[SMC_MODE_HI:SMC_MODE_LO], lnk.xtal_sel);

  // ****************************************************************
  // wake source filter per mode
  // ****************************************************************
  // sources arrive already qualified by their own enables, so this
  // filter only decides which kinds may end the present mode
  always_comb begin
    allow = '0;
    case (mode_reg)
      SMC_M_IDLE: begin
        allow = '1;
        allow[SMC_W_ACMP] = !lnk.cmp_disable;
      end
      SMC_M_ADCNR: begin
        allow[SMC_W_ADC] = 1'b1;
        allow[SMC_W_TWI] = 1'b1;
        allow[SMC_W_T2]  = 1'b1;
        allow[SMC_W_SPM] = 1'b1;
        allow[SMC_W_LVL] = 1'b1;
      end
      SMC_M_PSAVE: begin
        allow[SMC_W_TWI] = 1'b1;
        allow[SMC_W_LVL] = 1'b1;
        allow[SMC_W_T2]  = lnk.async_t2;
      end
      default: begin
        allow[SMC_W_TWI] = 1'b1;
        allow[SMC_W_LVL] = 1'b1;
      end
    endcase
  end
  assign wake = |(lnk.wake_src & allow);

  // ****************************************************************
  // sleep sequencer
  // ****************************************************************
  // reset pre-empts any wake in progress
  // a wake and a reset in one cycle: the reset wins, so the handler
  // never runs before the core restarts at the reset vector
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg <= SMC_RUN;
      mode_reg  <= SMC_M_IDLE;
      cnt_reg   <= 5'h00;
      isr_reg   <= 1'b0;
    end else begin
      isr_reg <= 1'b0;
      case (state_reg)
        SMC_RUN: begin
          if (enter) begin
            state_reg <= SMC_SLEEP;
            mode_reg  <= ctrl_reg[SMC_MODE_HI:SMC_MODE_LO];
          end
        end
        SMC_SLEEP: begin
          if (lnk.rst_req) begin
            state_reg <= SMC_RUN;
          end else if (wake) begin
            state_reg <= SMC_START;
            case (mode_reg)
              SMC_M_PDOWN, SMC_M_PSAVE: cnt_reg <= smc_startup(lnk.ck_sel, lnk.su_sel);
              SMC_M_STBY: cnt_reg <= SMC_STBY_CYC;
              default:    cnt_reg <= 5'h01;         // clocks still run, minimal restart
            endcase
          end
        end
        SMC_START: begin
          if (lnk.rst_req) begin
            state_reg <= SMC_RUN;
          end else if (cnt_reg <= 5'h01) begin
            state_reg <= SMC_HALT;
            cnt_reg   <= SMC_HALT_CYC;
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
          end
        end
        SMC_HALT: begin
          if (lnk.rst_req) begin
            state_reg <= SMC_RUN;
          end else if (cnt_reg <= 5'h01) begin
            state_reg <= SMC_RUN;
            isr_reg   <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
          end
        end
        default: state_reg <= SMC_RUN;
      endcase
    end
  end

  // conversion kick on entry into idle or adc noise reduction
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      adc_start_reg <= 1'b0;
    end else begin
      adc_start_reg <= enter && lnk.adc_enabled
                    && (ctrl_reg[SMC_MODE_HI:SMC_MODE_LO] == SMC_M_IDLE
                     || ctrl_reg[SMC_MODE_HI:SMC_MODE_LO] == SMC_M_ADCNR);
    end
  end

  // ****************************************************************
  // clock and oscillator gating
  // ****************************************************************
  // gating only stops clocks, so register file and sram keep contents
  // main oscillator stays on in standby so restart is only six cycles
  always_comb begin
    lnk.clk_en       = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1};
    lnk.main_osc_en  = 1'b1;
    lnk.timer_osc_en = lnk.async_t2;
    if (state_reg != SMC_RUN) begin
      lnk.clk_en.cpu   = 1'b0;
      lnk.clk_en.flash = 1'b0;
      case (mode_reg)
        SMC_M_IDLE: ;
        SMC_M_ADCNR: lnk.clk_en.io = 1'b0;
        SMC_M_PSAVE: begin
          lnk.clk_en = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, adc: 1'b0, asy: lnk.async_t2};
          lnk.main_osc_en = 1'b0;
        end
        SMC_M_STBY: begin
          lnk.clk_en = '0;
          lnk.timer_osc_en = 1'b0;
        end
        default: begin
          lnk.clk_en = '0;
          lnk.main_osc_en  = 1'b0;
          lnk.timer_osc_en = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // core-side status
  // ****************************************************************
  // halt covers sleep, start-up and the four extra halt cycles
  assign lnk.adc_start  = adc_start_reg;
  assign lnk.core_halt  = (state_reg != SMC_RUN);
  assign lnk.run_isr    = isr_reg;
  assign lnk.jump_reset = lnk.rst_req && (state_reg != SMC_RUN);
  assign lnk.asleep     = (state_reg == SMC_SLEEP);

endmodule
`default_nettype wire

// [smc_host.sv]
// Purpose: core-side end: software port, sleep instruction, wake inputs
// Assumes: software writes registers on the plain port
// Notes:   holds fuse and config settings for the device end
`timescale 1ns/1ps
`default_nettype none
module smc_host
  import smc_pkg::*;
(
  input  wire logic               clk_sys_i,
  input  wire logic               sys_rst_i,
  input  wire logic [3:0]         addr_i,
  input  wire logic [7:0]         wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [7:0]         rdata_o,
  input  wire logic               sleep_cmd_i,
  input  wire logic [SMC_W_N-1:0] wake_src_i,
  input  wire logic               rst_req_i,
  input  wire logic               adc_enabled_i,
  output logic                    halted_o,
  output logic                    run_isr_o,
  output logic                    jump_reset_o,
  smc_if.host                     lnk
);

  logic [7:0] cfg_reg;   // b0 async t2, b1 comparator off, b2 xtal, b5:4 su
  logic [3:0] ck_reg;
  logic [7:0] rdata_reg;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // fuses modelled as writable config so tests can reach every delay
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cfg_reg <= 8'h00;
      ck_reg  <= 4'h1;
    end else if (wr_i && addr_i == SMC_ADDR_CFG) begin
      cfg_reg <= wdata_i;
    end else if (wr_i && addr_i == SMC_ADDR_STATUS) begin
      ck_reg  <= wdata_i[3:0];
    end
  end

  // read data valid one cycle after the strobe only
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        SMC_ADDR_CTRL:   rdata_reg <= lnk.ctrl_rdata;
        SMC_ADDR_CFG:    rdata_reg <= cfg_reg;
        SMC_ADDR_STATUS: rdata_reg <= {lnk.asleep, lnk.core_halt, 2'h0, ck_reg};
        default:         rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign rdata_o = rdata_reg;

  // ****************************************************************
  // link drive
  // ****************************************************************
  // sleep only issued while the core runs; software sets enable first
  assign lnk.ctrl_wdata  = wdata_i;
  assign lnk.ctrl_we     = wr_i && addr_i == SMC_ADDR_CTRL;
  assign lnk.sleep_instr = sleep_cmd_i && !lnk.core_halt;
  assign lnk.wake_src    = wake_src_i;
  assign lnk.rst_req     = rst_req_i;
  assign lnk.async_t2    = cfg_reg[0];
  assign lnk.cmp_disable = cfg_reg[1];
  assign lnk.xtal_sel    = cfg_reg[2];
  assign lnk.su_sel      = cfg_reg[5:4];
  assign lnk.ck_sel      = ck_reg;
  assign lnk.adc_enabled = adc_enabled_i;
  assign halted_o        = lnk.core_halt;
  assign run_isr_o       = lnk.run_isr;
  assign jump_reset_o    = lnk.jump_reset;

endmodule
`default_nettype wire

// [smc_if.sv]
// Purpose: link between the sleep controller and the core side
// Assumes: one clock, both ends synchronous to clk_sys_i
// Notes:   no clocking block; the testbench joins both ends
`timescale 1ns/1ps
`default_nettype none
interface smc_if;
  import smc_pkg::*;
  logic [7:0]         ctrl_wdata;   // core write to control register
  logic               ctrl_we;
  logic [7:0]         ctrl_rdata;   // control register contents
  logic               sleep_instr;  // one-cycle sleep instruction
  logic [SMC_W_N-1:0] wake_src;     // raw wake requests
  logic               rst_req;      // any reset source during sleep
  logic               async_t2;     // timer 2 async clock selected
  logic               cmp_disable;  // comparator powered down
  logic               adc_enabled;
  logic [3:0]         ck_sel;       // clock source select fuses
  logic [1:0]         su_sel;       // start-up time fuses
  logic               xtal_sel;     // crystal/resonator option
  smc_clk_t           clk_en;
  logic               main_osc_en;
  logic               timer_osc_en;
  logic               adc_start;
  logic               core_halt;
  logic               run_isr;
  logic               jump_reset;
  logic               asleep;

  modport dev (
    input  ctrl_wdata, ctrl_we, sleep_instr, wake_src, rst_req, async_t2,
           cmp_disable, adc_enabled, ck_sel, su_sel, xtal_sel,
    output ctrl_rdata, clk_en, main_osc_en, timer_osc_en, adc_start,
           core_halt, run_isr, jump_reset, asleep
  );
  modport host (
    output ctrl_wdata, ctrl_we, sleep_instr, wake_src, rst_req, async_t2,
           cmp_disable, adc_enabled, ck_sel, su_sel, xtal_sel,
    input  ctrl_rdata, clk_en, main_osc_en, timer_osc_en, adc_start,
           core_halt, run_isr, jump_reset, asleep
  );
endinterface
`default_nettype wire

// [smc_pkg.sv]
// Purpose: shared constants and types for the sleep mode controller
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes:   both ends import this package
// Behaviour
// - sleep only with enable bit and instruction
// - mode codes 000,001,010,011,110; 100,101 reserved
// - wake by interrupt halts core four extra cycles
// - register file and sram kept across sleep
// - reset during sleep restarts at reset vector
// - control byte: enable b7, mode b6-4, sense b3-0
// - idle stops only cpu and flash clocks
// - idle wakes on every enabled interrupt
// - idle or adc mode starts adc conversion
// - adc mode stops io, cpu, flash clocks
// - adc mode wakes on listed sources only
// - power-down stops all clocks, limited wake
// - level wake source held until recognised
// - power-down wake delayed by fuse start-up time
// - power-save keeps async timer 2 running
// - power-save timer wake needs both enables
// - software prefers power-down without async timer
// - standby keeps oscillator, wakes in six cycles
// - software sets enable just before sleeping
// - comparator disable removes idle comparator wake
// - start-up delay follows clock and fuse settings
package smc_pkg;

  // ****************************************************************
  // control register layout
  // ****************************************************************
  localparam int        SMC_SE_POS       = 7;
  localparam int        SMC_MODE_HI      = 6;
  localparam int        SMC_MODE_LO      = 4;
  localparam int        SMC_SENSE_HI     = 3;
  localparam logic [7:0] SMC_CTRL_RESET  = 8'h00;

  // software register offsets decoded by the core-side end
  localparam logic [3:0] SMC_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] SMC_ADDR_CFG    = 4'h1;
  localparam logic [3:0] SMC_ADDR_STATUS = 4'h2;

  // ****************************************************************
  // mode codes
  // ****************************************************************
  localparam logic [2:0] SMC_M_IDLE  = 3'h0;
  localparam logic [2:0] SMC_M_ADCNR = 3'h1;
  localparam logic [2:0] SMC_M_PDOWN = 3'h2;
  localparam logic [2:0] SMC_M_PSAVE = 3'h3;
  localparam logic [2:0] SMC_M_STBY  = 3'h6;

  // ****************************************************************
  // timing in clock cycles
  // ****************************************************************
  localparam logic [4:0] SMC_HALT_CYC    = 5'h04;
  localparam logic [4:0] SMC_SU_SHORT    = 5'h06;
  localparam logic [4:0] SMC_SU_LONG     = 5'h12;
  localparam logic [4:0] SMC_STBY_CYC    = 5'h06;

  // clock source selection codes (low nibble of the fuses)
  localparam logic [3:0] SMC_CK_EXTCLK   = 4'h0;
  localparam logic [3:0] SMC_CK_RC_LO    = 4'h1;
  localparam logic [3:0] SMC_CK_RC_HI    = 4'h4;
  localparam logic [3:0] SMC_CK_ERC_LO   = 4'h5;
  localparam logic [3:0] SMC_CK_ERC_HI   = 4'h8;

  // wake source vector bit positions
  localparam int SMC_W_ADC   = 0;
  localparam int SMC_W_TWI   = 1;
  localparam int SMC_W_T2    = 2;
  localparam int SMC_W_SPM   = 3;
  localparam int SMC_W_LVL   = 4;  // level on external_interrupt_0/1
  localparam int SMC_W_EDGE  = 5;  // edge on external_interrupt_0/1
  localparam int SMC_W_ACMP  = 6;
  localparam int SMC_W_OTHER = 7;
  localparam int SMC_W_N     = 8;

  // state: gray code along run -> sleep -> startup -> halt
  typedef enum logic [1:0] {
    SMC_RUN   = 2'b00,
    SMC_SLEEP = 2'b01,
    SMC_START = 2'b11,
    SMC_HALT  = 2'b10
  } smc_state_t;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
  } smc_clk_t;

endpackage
